// ==== scfc_cfg.svh ====
// offsets, field positions, reset values and divider counts of the format config bank
`ifndef SCFC_CFG_SVH
`define SCFC_CFG_SVH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define SCFC_ADDR_W          5
`define SCFC_OFF_IVEC        5'h00
`define SCFC_OFF_RXPAR       5'h04
`define SCFC_OFF_LFMT        5'h08
`define SCFC_OFF_STATUS      5'h0C

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SCFC_RX_LEN_HI       7
`define SCFC_RX_LEN_LO       6
`define SCFC_RX_EN_BIT       0
`define SCFC_CLK_MUL_HI      7
`define SCFC_CLK_MUL_LO      6
`define SCFC_SYNC_HI         5
`define SCFC_SYNC_LO         4
`define SCFC_STOP_HI         3
`define SCFC_STOP_LO         2
`define SCFC_PAR_EVEN_BIT    1
`define SCFC_PAR_EN_BIT      0

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SCFC_RST_IVEC        8'h00
`define SCFC_RST_RXPAR       8'h00
`define SCFC_RST_LFMT        8'h04

// ----------------------------------------------------------------------------
// bit-rate divider terminal counts (divide minus one)
// ----------------------------------------------------------------------------
`define SCFC_DIV1_TC         6'h00
`define SCFC_DIV16_TC        6'h0F
`define SCFC_DIV32_TC        6'h1F
`define SCFC_DIV64_TC        6'h3F

// ----------------------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------------------
`define SCFC_RESP_OKAY       2'h0
`define SCFC_RESP_SLVERR     2'h2

`endif

// ==== scfc_pkg.sv ====
// types of the serial channel format config bank
package scfc_pkg;

  // --------------------------------------------------------------------------
  // field encodings, in register code order
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {CLK_X1, CLK_X16, CLK_X32, CLK_X64} scfc_clk_mul_t;
  typedef enum logic [1:0] {SYNC_8BIT, SYNC_16BIT, SYNC_FLAG, SYNC_EXT} scfc_sync_t;
  typedef enum logic [1:0] {STOP_SYNC, STOP_ONE, STOP_ONE_HALF, STOP_TWO} scfc_stop_t;

  // --------------------------------------------------------------------------
  // bus write channel states
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {WR_COLLECT, WR_RESP} scfc_wr_state_t;

  // --------------------------------------------------------------------------
  // decoded format handed to the datapaths
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0]    char_bits;
    scfc_clk_mul_t clk_mul;
    logic          sync_en;
    scfc_sync_t    sync_mode;
    scfc_stop_t    stop;
    logic          parity_en;
    logic          parity_even;
    logic          rx_en;
  } scfc_fmt_t;

endpackage : scfc_pkg

// ==== scfc_rate_div.sv ====
// bit-rate tick divider selected by the clock multiplier field
`timescale 1ns/1ns
`include "scfc_cfg.svh"

module scfc_rate_div
  import scfc_pkg::*;
(
  // clock and reset
  input  wire logic          sys_clk_i,
  input  wire logic          rstn_i,
  input  wire logic          ce_i,
  // divider select
  input  wire scfc_clk_mul_t clk_mul_i,
  // bit-rate tick
  output logic               tick_o
);

  logic [5:0] cnt_ff;
  logic [5:0] tc;

  always_comb begin
    case (clk_mul_i)
      CLK_X1:  tc = `SCFC_DIV1_TC;
      CLK_X16: tc = `SCFC_DIV16_TC;
      CLK_X32: tc = `SCFC_DIV32_TC;
      default: tc = `SCFC_DIV64_TC;
    endcase
  end

  // counter restarts when the select shrinks below it
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff <= 6'h00;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      if (cnt_ff >= tc) begin
        cnt_ff <= 6'h00;
        tick_o <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 6'h01;
        tick_o <= 1'b0;
      end
    end
  end

endmodule : scfc_rate_div

// ==== scfc_top.sv ====
// serial channel format config bank with axi4-lite slave and character check
// Operation
// - receive length field picks 5/7/6/8 bits
// - multiplier field divides clock by 1/16/32/64
// - sync field picks 8/16-bit, flag or external
// - stop field: 00 sync, else 1/1.5/2 stops
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`include "scfc_cfg.svh"

module scfc_top
  import scfc_pkg::*;
(
  // clock, reset, enable
  input  wire logic                    sys_clk_i,
  input  wire logic                    rstn_i,
  input  wire logic                    ce_i,
  // axi4-lite write
  input  wire logic [`SCFC_ADDR_W-1:0] awaddr_i,
  input  wire logic                    awvalid_i,
  output logic                         awready_o,
  input  wire logic [31:0]             wdata_i,
  input  wire logic [3:0]              wstrb_i,
  input  wire logic                    wvalid_i,
  output logic                         wready_o,
  output logic [1:0]                   bresp_o,
  output logic                         bvalid_o,
  input  wire logic                    bready_i,
  // axi4-lite read
  input  wire logic [`SCFC_ADDR_W-1:0] araddr_i,
  input  wire logic                    arvalid_i,
  output logic                         arready_o,
  output logic [31:0]                  rdata_o,
  output logic [1:0]                   rresp_o,
  output logic                         rvalid_o,
  input  wire logic                    rready_i,
  // receive character check
  input  wire logic [7:0]              rx_data_i,
  input  wire logic                    rx_par_bit_i,
  input  wire logic                    rx_valid_i,
  output logic [7:0]                   rx_data_o,
  output logic                         rx_valid_o,
  output logic                         rx_par_err_o,
  // transmit parity generation
  input  wire logic [7:0]              tx_data_i,
  output logic                         tx_par_bit_o,
  // decoded format and vector
  output scfc_fmt_t                    fmt_o,
  output logic [7:0]                   int_vector_o,
  output logic                         bit_tick_o
);

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  logic [7:0]                  ivec_ff;
  logic [7:0]                  rxpar_ff;
  logic [7:0]                  lfmt_ff;
  logic [`SCFC_ADDR_W-1:0]     awaddr_ff;
  logic [7:0]                  wbyte_ff;
  logic                        wlane_ff;
  scfc_wr_state_t              wr_state_ff;
  scfc_fmt_t                   nxt_fmt;
  logic [7:0]                  len_mask;
  logic [7:0]                  rx_masked;
  logic [7:0]                  tx_masked;
  logic                        wr_commit;
  logic                        wr_hit;
  logic [31:0]                 nxt_rdata;
  logic                        rd_hit;

  assign int_vector_o = ivec_ff;

  // --------------------------------------------------------------------------
  // field decode
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_fmt = '0;
    case (rxpar_ff[`SCFC_RX_LEN_HI:`SCFC_RX_LEN_LO])
      2'h0:    nxt_fmt.char_bits = 4'h5;
      2'h1:    nxt_fmt.char_bits = 4'h7;
      2'h2:    nxt_fmt.char_bits = 4'h6;
      default: nxt_fmt.char_bits = 4'h8;
    endcase
    nxt_fmt.clk_mul     = scfc_clk_mul_t'(lfmt_ff[`SCFC_CLK_MUL_HI:`SCFC_CLK_MUL_LO]);
    nxt_fmt.sync_mode   = scfc_sync_t'(lfmt_ff[`SCFC_SYNC_HI:`SCFC_SYNC_LO]);
    nxt_fmt.stop        = scfc_stop_t'(lfmt_ff[`SCFC_STOP_HI:`SCFC_STOP_LO]);
    nxt_fmt.sync_en     = (nxt_fmt.stop == STOP_SYNC);
    nxt_fmt.parity_en   = lfmt_ff[`SCFC_PAR_EN_BIT];
    nxt_fmt.parity_even = lfmt_ff[`SCFC_PAR_EVEN_BIT];
    nxt_fmt.rx_en       = rxpar_ff[`SCFC_RX_EN_BIT];
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fmt_o <= '0;
    end else if (ce_i) begin
      fmt_o <= nxt_fmt;
    end
  end

  // --------------------------------------------------------------------------
  // bit-rate divider
  // --------------------------------------------------------------------------
  // clock division
  scfc_rate_div u_rate_div (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .ce_i      (ce_i),
    .clk_mul_i (fmt_o.clk_mul),
    .tick_o    (bit_tick_o)
  );

  // --------------------------------------------------------------------------
  // character length and parity
  // --------------------------------------------------------------------------
  // character length mask
  always_comb begin
    case (fmt_o.char_bits)
      4'h5:    len_mask = 8'h1F;
      4'h6:    len_mask = 8'h3F;
      4'h7:    len_mask = 8'h7F;
      default: len_mask = 8'hFF;
    endcase
  end

  assign rx_masked = rx_data_i & len_mask;
  assign tx_masked = tx_data_i & len_mask;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_data_o    <= 8'h00;
      rx_valid_o   <= 1'b0;
      rx_par_err_o <= 1'b0;
    end else if (ce_i) begin
      rx_valid_o   <= rx_valid_i & fmt_o.rx_en;
      rx_par_err_o <= rx_valid_i & fmt_o.rx_en & fmt_o.parity_en &
                      ((^rx_masked ^ rx_par_bit_i) != ~fmt_o.parity_even);
      if (rx_valid_i && fmt_o.rx_en) begin
        rx_data_o <= rx_masked;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_par_bit_o <= 1'b0;
    end else if (ce_i) begin
      tx_par_bit_o <= fmt_o.parity_en & (fmt_o.parity_even ? ^tx_masked : ~^tx_masked);
    end
  end

  // --------------------------------------------------------------------------
  // axi4-lite write channel
  // --------------------------------------------------------------------------
  assign wr_commit = (wr_state_ff == WR_COLLECT) && !awready_o && !wready_o;
  assign wr_hit    = (awaddr_ff == `SCFC_OFF_IVEC) || (awaddr_ff == `SCFC_OFF_RXPAR) ||
                     (awaddr_ff == `SCFC_OFF_LFMT);

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      awready_o   <= 1'b1;
      wready_o    <= 1'b1;
      bvalid_o    <= 1'b0;
      bresp_o     <= `SCFC_RESP_OKAY;
      awaddr_ff   <= '0;
      wbyte_ff    <= 8'h00;
      wlane_ff    <= 1'b0;
      wr_state_ff <= WR_COLLECT;
    end else if (ce_i) begin
      case (wr_state_ff)
        WR_COLLECT: begin
          if (awvalid_i && awready_o) begin
            awaddr_ff <= {awaddr_i[`SCFC_ADDR_W-1:2], 2'h0};
            awready_o <= 1'b0;
          end
          if (wvalid_i && wready_o) begin
            wbyte_ff <= wdata_i[7:0];
            wlane_ff <= wstrb_i[0];
            wready_o <= 1'b0;
          end
          if (wr_commit) begin
            bvalid_o    <= 1'b1;
            bresp_o     <= wr_hit ? `SCFC_RESP_OKAY : `SCFC_RESP_SLVERR;
            wr_state_ff <= WR_RESP;
          end
        end
        WR_RESP: begin
          if (bready_i) begin
            bvalid_o    <= 1'b0;
            awready_o   <= 1'b1;
            wready_o    <= 1'b1;
            wr_state_ff <= WR_COLLECT;
          end
        end
        default: wr_state_ff <= WR_COLLECT;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ivec_ff  <= `SCFC_RST_IVEC;
      rxpar_ff <= `SCFC_RST_RXPAR;
      lfmt_ff  <= `SCFC_RST_LFMT;
    end else if (ce_i && wr_commit && wlane_ff) begin
      case (awaddr_ff)
        `SCFC_OFF_IVEC:  ivec_ff  <= wbyte_ff;
        `SCFC_OFF_RXPAR: rxpar_ff <= wbyte_ff;
        `SCFC_OFF_LFMT:  lfmt_ff  <= wbyte_ff;
        default:         ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // axi4-lite read channel
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    rd_hit    = 1'b1;
    case ({araddr_i[`SCFC_ADDR_W-1:2], 2'h0})
      `SCFC_OFF_IVEC:   nxt_rdata[7:0] = ivec_ff;
      `SCFC_OFF_RXPAR:  nxt_rdata[7:0] = rxpar_ff;
      `SCFC_OFF_LFMT:   nxt_rdata[7:0] = lfmt_ff;
      `SCFC_OFF_STATUS: nxt_rdata[14:0] = {rx_par_err_o, fmt_o};
      default:          rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      arready_o <= 1'b1;
      rvalid_o  <= 1'b0;
      rdata_o   <= 32'h0000_0000;
      rresp_o   <= `SCFC_RESP_OKAY;
    end else if (ce_i) begin
      if (arvalid_i && arready_o) begin
        arready_o <= 1'b0;
        rvalid_o  <= 1'b1;
        rdata_o   <= nxt_rdata;
        rresp_o   <= rd_hit ? `SCFC_RESP_OKAY : `SCFC_RESP_SLVERR;
      end else if (rvalid_o && rready_i) begin
        rvalid_o  <= 1'b0;
        arready_o <= 1'b1;
      end
    end
  end

endmodule : scfc_top

// ==== scfc_chk.sv ====
// concurrent checks on the format config bank ports
`timescale 1ns/1ns

module scfc_chk
  import scfc_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       ce_i,
  // character path
  input  wire logic [7:0] rx_data_i,
  input  wire logic       rx_par_bit_i,
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_data_o,
  input  wire logic       rx_valid_o,
  input  wire logic       rx_par_err_o,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_par_bit_o,
  // format and tick
  input  wire scfc_fmt_t  fmt_o,
  input  wire logic       bit_tick_o
);
  logic [7:0]    msk;
  logic [6:0]    tc;
  logic [6:0]    cnt_ff;
  scfc_clk_mul_t mul_ff;
  logic          chg_ff;
  logic          err_ff;
  logic          txp_ff;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  assign msk = 8'hFF >> (4'h8 - fmt_o.char_bits);
  assign tc  = (fmt_o.clk_mul == CLK_X1) ? 7'h00 : (7'h08 << fmt_o.clk_mul) - 7'h01;

  // cycles since last tick, expected parity outcomes
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff <= 7'h00;
      mul_ff <= CLK_X1;
      chg_ff <= 1'b1;
      err_ff <= 1'b0;
      txp_ff <= 1'b0;
    end else if (ce_i) begin
      cnt_ff <= bit_tick_o ? 7'h00 : cnt_ff + 7'h01;
      mul_ff <= fmt_o.clk_mul;
      chg_ff <= (fmt_o.clk_mul != mul_ff) | (chg_ff & ~bit_tick_o);
      err_ff <= fmt_o.parity_en & ((^(rx_data_i & msk) ^ rx_par_bit_i) == fmt_o.parity_even);
      txp_ff <= fmt_o.parity_en & (^(tx_data_i & msk) ^ ~fmt_o.parity_even);
    end
  end

  sequence rx_take_s;
    ce_i && rx_valid_i && fmt_o.rx_en;
  endsequence

  len_code_a: assert property (
    $past(rstn_i) |-> fmt_o.char_bits inside {4'h5, 4'h6, 4'h7, 4'h8})
    else $error("character length outside 5 to 8");
  rx_mask_a: assert property (
    rx_take_s |=> rx_valid_o && rx_data_o == ($past(rx_data_i) & $past(msk)))
    else $error("received character not masked to length");
  tick_gap_a: assert property (
    (bit_tick_o && !chg_ff && fmt_o.clk_mul == mul_ff) |-> cnt_ff == tc)
    else $error("tick spacing differs from divider");
  tick_due_a: assert property (
    (!chg_ff && fmt_o.clk_mul == mul_ff) |-> cnt_ff <= tc)
    else $error("tick late for divider");
  sync_sel_a: assert property (
    $past(rstn_i) |-> fmt_o.sync_en == (fmt_o.stop == STOP_SYNC))
    else $error("sync enable does not follow stop field");
  rx_off_a: assert property (
    (rx_valid_i && !fmt_o.rx_en) |=> !rx_valid_o)
    else $error("character accepted while receiver off");
  par_err_a: assert property (
    rx_take_s |=> rx_par_err_o == err_ff)
    else $error("parity error flag wrong");
  tx_par_a: assert property (
    $past(rstn_i) |-> tx_par_bit_o == txp_ff)
    else $error("transmit parity bit wrong");
endmodule : scfc_chk

// ==== scfc_line_peer.sv ====
// serial line peer handing received characters to the bank
`timescale 1ns/1ns

module scfc_line_peer (
  // clock
  input  wire logic  sys_clk_i,
  // character towards the bank
  output logic [7:0] rx_data_o,
  output logic       rx_par_bit_o,
  output logic       rx_valid_o
);
  initial begin
    rx_data_o    = 8'h00;
    rx_par_bit_o = 1'b0;
    rx_valid_o   = 1'b0;
  end

  // idle cycles, one character, then lines show the inverse
  task automatic send(input logic [7:0] d, input logic p, input int idle);
    repeat (idle) @(posedge sys_clk_i);
    @(posedge sys_clk_i);
    rx_data_o    <= d;
    rx_par_bit_o <= p;
    rx_valid_o   <= 1'b1;
    @(posedge sys_clk_i);
    rx_data_o    <= ~d;
    rx_par_bit_o <= ~p;
    rx_valid_o   <= 1'b0;
  endtask : send
endmodule : scfc_line_peer

// ==== scfc_tb_top.sv ====
// testbench of the serial channel format config bank
`timescale 1ns/1ns
`include "scfc_cfg.svh"

module scfc_tb_top
  import scfc_pkg::*;
;
  logic                    sys_clk_i, rstn_i, ce_i;
  logic [`SCFC_ADDR_W-1:0] awaddr_i, araddr_i;
  logic                    awvalid_i, awready_o, wvalid_i, wready_o, bvalid_o, bready_i;
  logic                    arvalid_i, arready_o, rvalid_o, rready_i;
  logic [31:0]             wdata_i, rdata_o, rd;
  logic [3:0]              wstrb_i;
  logic [1:0]              bresp_o, rresp_o, rsp;
  logic [7:0]              rx_data_i, rx_data_o, tx_data_i, int_vector_o;
  logic                    rx_par_bit_i, rx_valid_i, rx_valid_o, rx_par_err_o, tx_par_bit_o, bit_tick_o;
  scfc_fmt_t               fmt_o;
  int                      mismatches, comparisons, g;
  logic [3:0]              lens [4] = '{4'h5, 4'h7, 4'h6, 4'h8};
  int                      divs [4] = '{1, 16, 32, 64};

  scfc_top uut (
    .sys_clk_i    (sys_clk_i),
    .rstn_i       (rstn_i),
    .ce_i         (ce_i),
    .awaddr_i     (awaddr_i),
    .awvalid_i    (awvalid_i),
    .awready_o    (awready_o),
    .wdata_i      (wdata_i),
    .wstrb_i      (wstrb_i),
    .wvalid_i     (wvalid_i),
    .wready_o     (wready_o),
    .bresp_o      (bresp_o),
    .bvalid_o     (bvalid_o),
    .bready_i     (bready_i),
    .araddr_i     (araddr_i),
    .arvalid_i    (arvalid_i),
    .arready_o    (arready_o),
    .rdata_o      (rdata_o),
    .rresp_o      (rresp_o),
    .rvalid_o     (rvalid_o),
    .rready_i     (rready_i),
    .rx_data_i    (rx_data_i),
    .rx_par_bit_i (rx_par_bit_i),
    .rx_valid_i   (rx_valid_i),
    .rx_data_o    (rx_data_o),
    .rx_valid_o   (rx_valid_o),
    .rx_par_err_o (rx_par_err_o),
    .tx_data_i    (tx_data_i),
    .tx_par_bit_o (tx_par_bit_o),
    .fmt_o        (fmt_o),
    .int_vector_o (int_vector_o),
    .bit_tick_o   (bit_tick_o)
  );
  scfc_line_peer peer (.sys_clk_i(sys_clk_i), .rx_data_o(rx_data_i), .rx_par_bit_o(rx_par_bit_i),
                       .rx_valid_o(rx_valid_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [3:0] s = 4'hF);
    @(posedge sys_clk_i);
    awaddr_i  <= a;
    wdata_i   <= {24'h0, d};
    wstrb_i   <= s;
    awvalid_i <= 1'b1;
    wvalid_i  <= 1'b1;
    bready_i  <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (awready_o === 1'b1) awvalid_i <= 1'b0;
      if (wready_o === 1'b1) wvalid_i <= 1'b0;
    end while (bvalid_o !== 1'b1);
    rsp = bresp_o;
    bready_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
  endtask : wr

  task automatic rdt(input logic [4:0] a);
    @(posedge sys_clk_i);
    araddr_i  <= a;
    arvalid_i <= 1'b1;
    rready_i  <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (arready_o === 1'b1) arvalid_i <= 1'b0;
    end while (rvalid_o !== 1'b1);
    rd  = rdata_o;
    rsp = rresp_o;
    rready_i <= 1'b0;
  endtask : rdt

  // edges from one tick to the next
  task automatic gap();
    do @(posedge sys_clk_i); while (bit_tick_o !== 1'b1);
    g = 0;
    do begin
      @(posedge sys_clk_i);
      g++;
    end while (bit_tick_o !== 1'b1);
  endtask : gap

  task automatic end_of_test();
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  initial begin
    {rstn_i, awaddr_i, awvalid_i, wdata_i, wvalid_i, bready_i, araddr_i, arvalid_i, rready_i} = '0;
    ce_i      = 1'b1;
    wstrb_i   = 4'hF;
    tx_data_i = 8'h07;
    repeat (8) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    rdt(`SCFC_OFF_RXPAR);
    chk(rd, 32'h0);
    rdt(`SCFC_OFF_LFMT);
    chk(rd, 32'h4);
    chk(fmt_o, 14'h1408);
    peer.send(8'h55, 1'b0, 0);
    #1;
    chk(rx_valid_o, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(`SCFC_OFF_RXPAR, {i[1:0], 6'h01});
      peer.send(8'hFF, 1'b0, i);
      #1;
      chk({rx_valid_o, fmt_o.char_bits, rx_data_o}, {1'b1, lens[i], 8'hFF >> (8 - lens[i])});
    end
    for (int i = 0; i < 4; i++) begin
      wr(`SCFC_OFF_LFMT, {i[1:0], 6'h04});
      gap();
      gap();
      chk(g, divs[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(`SCFC_OFF_LFMT, {2'h0, i[1:0], 4'h0});
      chk({fmt_o.sync_en, fmt_o.sync_mode}, {1'b1, i[1:0]});
      wr(`SCFC_OFF_LFMT, {4'h0, i[1:0], 2'h0});
      chk({fmt_o.sync_en, fmt_o.stop}, {i == 0, i[1:0]});
    end
    wr(`SCFC_OFF_RXPAR, 8'hC1);
    for (int i = 0; i < 8; i++) begin
      wr(`SCFC_OFF_LFMT, {6'h01, i[1], i[2]});
      peer.send(8'h03, i[0], 0);
      #1;
      chk(rx_par_err_o, i[2] & (i[0] == i[1]));
      chk(tx_par_bit_o, i[2] & i[1]);
    end
    // enable low: a character must be ignored
    @(posedge sys_clk_i);
    ce_i <= 1'b0;
    peer.send(8'h81, 1'b0, 0);
    #1;
    chk({rx_valid_o, rx_data_o}, {1'b0, 8'h03});
    @(posedge sys_clk_i);
    ce_i <= 1'b1;
    rdt(`SCFC_OFF_STATUS);
    chk(rd, 32'h200F);
    wr(`SCFC_OFF_IVEC, 8'hA5);
    rdt(`SCFC_OFF_IVEC);
    chk(rd, 32'hA5);
    chk(int_vector_o, 8'hA5);
    wr(`SCFC_OFF_IVEC, 8'h5A, 4'hE);
    chk(rsp, `SCFC_RESP_OKAY);
    chk(int_vector_o, 8'hA5);
    wr(`SCFC_OFF_STATUS, 8'hFF);
    chk(rsp, `SCFC_RESP_SLVERR);
    rdt(5'h10);
    chk(rsp, `SCFC_RESP_SLVERR);
    chk(rd, 32'h0);
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    mismatches++;
    end_of_test();
  end
endmodule : scfc_tb_top

bind scfc_top scfc_chk u_chk (
  .sys_clk_i    (sys_clk_i),
  .rstn_i       (rstn_i),
  .ce_i         (ce_i),
  .rx_data_i    (rx_data_i),
  .rx_par_bit_i (rx_par_bit_i),
  .rx_valid_i   (rx_valid_i),
  .rx_data_o    (rx_data_o),
  .rx_valid_o   (rx_valid_o),
  .rx_par_err_o (rx_par_err_o),
  .tx_data_i    (tx_data_i),
  .tx_par_bit_o (tx_par_bit_o),
  .fmt_o        (fmt_o),
  .bit_tick_o   (bit_tick_o)
);
